/* File: common/liu_diag_pkg.sv */
// Purpose: Shared constants for the line interface diagnostic register bank
// Assumes: Byte-wide registers on a 6-bit register address
// Notes:   Loop codes feed the datapath muxes directly
package liu_diag_pkg;
	// Register offsets
	localparam logic [5:0] LINE_CTRL_ADDR  = 6'h06;
	localparam logic [5:0] ATTEN_CTRL_ADDR = 6'h07;
	localparam logic [5:0] IRQ_EN_ADDR     = 6'h20;
	localparam logic [5:0] IRQ_ST_ADDR     = 6'h21;
	localparam logic [5:0] ERR_HIGH_ADDR   = 6'h30;
	localparam logic [5:0] ERR_LOW_ADDR    = 6'h31;
	localparam logic [5:0] ERR_HOLD_ADDR   = 6'h38;
	localparam logic [5:0] DEV_ID_ADDR     = 6'h3E;
	localparam logic [5:0] SI_REV_ADDR     = 6'h3F;

	// Field positions
	localparam int NEAR_LOOP_BIT     = 3;
	localparam int FAR_LOOP_BIT      = 4;
	localparam int PATTERN_EN_BIT    = 5;
	localparam int ATTEN_A_BIT       = 0;
	localparam int ATTEN_PATH_BIT    = 1;
	localparam int ATTEN_B_BIT       = 2;
	localparam int PTR_RESET_BIT     = 3;
	localparam int IRQ_BIT           = 0;

	// Values after reset
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam logic [7:0] ZERO_BYTE     = 8'h00;

	// Counter width
	localparam int ERR_COUNT_W = 16;

	// Loopback selection codes
	typedef enum logic [1:0] {
		LOOP_NORMAL       = 2'h0,
		LOOP_ANALOG_LOCAL = 2'h1,
		LOOP_REMOTE       = 2'h2,
		LOOP_DIGITAL      = 2'h3
	} loop_mode_t;
endpackage : liu_diag_pkg

/* File: design/err_counter.sv */
// Purpose: Saturating test-pattern error counter with synchronous clear
// Assumes: Error pulses are on the same clock
// Notes:   An error in the clear cycle is kept as a count of one
module err_counter #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	// Control
	input  wire logic             i_count_en,
	input  wire logic             i_err,
	input  wire logic             i_clear,
	// Count
	output logic [WIDTH-1:0]      o_count
);
	logic [WIDTH-1:0] count_r;
	logic             bump;

	assign bump    = i_count_en & i_err;
	assign o_count = count_r;

	// Saturate rather than wrap so a huge error burst never reads as small
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_r <= '0;
		end else if (i_clear) begin
			count_r <= {{(WIDTH-1){1'b0}}, bump};
		end else if (bump && !(&count_r)) begin
			count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule // err_counter

/* File: design/liu_diag_control_registers.sv */
// Purpose: Diagnostic control and status register bank of the line interface
// Assumes: Serial port decoder delivers one-cycle read and write strobes
// Notes:   Read data is registered and valid one cycle after the read strobe
//
// Contract
// RULE_01 - The far and near loop bits pick normal, analog local, remote or digital loopback.
// RULE_02 - Pattern test enable sends the long pattern at E3 rate, the short one otherwise, and enables detection.
// RULE_03 - While pattern test is on, each detected bit error adds one to a 16-bit counter; the code holds the count at its full value instead of adding.
// RULE_04 - Reading one counter byte copies the other byte into the holding register and clears the counter.
// RULE_05 - Attenuator mode bits give 16-bit depth, 32-bit depth, or disable when the first bit is set.
// RULE_06 - The path bit places the attenuator in the transmit path when one, the receive path when zero.
// RULE_07 - The pointer reset bit resets both attenuator FIFO pointers.
// RULE_08 - The global interrupt enable bit enables interrupt signalling and resets to zero.
// RULE_09 - The global pending bit reads one when any interrupt needs service and resets to zero; the code also requires the global enable set.
// RULE_10 - The high counter register returns counter bits 15 to 8 and clears on read.
// RULE_11 - The low counter register returns counter bits 7 to 0 and clears on read.
// RULE_12 - The identification register returns a fixed code and ignores writes.
// RULE_13 - The revision register returns a fixed number and ignores writes.
// RULE_14 - Reserved addresses read as zero and ignore writes.
module liu_diag_control_registers #(
	parameter logic [7:0] DEVICE_ID   = 8'h5A,	// Arbitrary value
	parameter logic [7:0] SILICON_REV = 8'h02	// Arbitrary value
) (
	// Clock and reset
	input  wire logic                          I_SYS_CLK,
	input  wire logic                          I_ARST_N,
	// Register port
	input  wire logic [5:0]                    I_REG_ADDR,
	input  wire logic                          I_REG_WR,
	input  wire logic [7:0]                    I_REG_WDATA,
	input  wire logic                          I_REG_RD,
	output logic [7:0]                         O_REG_RDATA,
	output logic                               O_REG_RVALID,
	// Datapath status
	input  wire logic                          I_E3_RATE,
	input  wire logic                          I_BIT_ERROR,
	input  wire logic                          I_IRQ_SOURCE,
	// Datapath control
	output liu_diag_pkg::loop_mode_t           O_LOOP_MODE,
	output logic                               O_PATTERN_TX_EN,
	output logic                               O_PATTERN_LONG,
	output logic                               O_PATTERN_DET_EN,
	output logic                               O_ATTEN_EN,
	output logic                               O_ATTEN_DEPTH_32,
	output logic                               O_ATTEN_IN_TX,
	output logic                               O_FIFO_PTR_RESET,
	output logic                               O_IRQ_ENABLE,
	output logic                               O_IRQ_PENDING
);
	import liu_diag_pkg::*;

	logic [7:0]             line_ctrl_r;
	logic [7:0]             atten_ctrl_r;
	logic                   global_irq_enable_r;
	logic                   global_irq_pending_r;
	logic [7:0]             error_count_holding_r;
	logic [7:0]             rdata_r;
	logic                   rvalid_r;
	logic [ERR_COUNT_W-1:0] err_count;
	logic                   rd_high;
	logic                   rd_low;
	logic                   pattern_test_enable;
	logic                   far_loop_select;
	logic                   near_loop_select;
	logic                   atten_mode_bit_a;
	logic                   atten_mode_bit_b;

	function automatic logic hit(input logic [5:0] addr, input logic [5:0] target);
		hit = (addr == target);
	endfunction

	assign rd_high = I_REG_RD && hit(I_REG_ADDR, ERR_HIGH_ADDR);
	assign rd_low  = I_REG_RD && hit(I_REG_ADDR, ERR_LOW_ADDR);

	// Control register writes; unmapped writes fall through untouched
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			line_ctrl_r         <= REG_RESET_VAL;
			atten_ctrl_r        <= REG_RESET_VAL;
			global_irq_enable_r <= 1'b0;	// [RULE_08]
		end else if (I_REG_WR) begin
			if (hit(I_REG_ADDR, LINE_CTRL_ADDR)) begin
				line_ctrl_r <= I_REG_WDATA & 8'h38;
			end
			if (hit(I_REG_ADDR, ATTEN_CTRL_ADDR)) begin
				atten_ctrl_r <= I_REG_WDATA & 8'h0F;
			end
			if (hit(I_REG_ADDR, IRQ_EN_ADDR)) begin
				global_irq_enable_r <= I_REG_WDATA[IRQ_BIT];	// [RULE_08]
			end
		end
	end

	assign far_loop_select     = line_ctrl_r[FAR_LOOP_BIT];
	assign near_loop_select    = line_ctrl_r[NEAR_LOOP_BIT];
	assign pattern_test_enable = line_ctrl_r[PATTERN_EN_BIT];
	assign atten_mode_bit_a    = atten_ctrl_r[ATTEN_A_BIT];
	assign atten_mode_bit_b    = atten_ctrl_r[ATTEN_B_BIT];

	// Codes match {far, near} so the mux needs no table
	assign O_LOOP_MODE      = loop_mode_t'({far_loop_select, near_loop_select});	// [RULE_01]
	assign O_PATTERN_TX_EN  = pattern_test_enable;	// [RULE_02]
	assign O_PATTERN_LONG   = pattern_test_enable & I_E3_RATE;	// [RULE_02]
	assign O_PATTERN_DET_EN = pattern_test_enable;	// [RULE_02]
	assign O_ATTEN_EN       = !atten_mode_bit_a;	// [RULE_05]
	assign O_ATTEN_DEPTH_32 = !atten_mode_bit_a & atten_mode_bit_b;	// [RULE_05]
	assign O_ATTEN_IN_TX    = atten_ctrl_r[ATTEN_PATH_BIT];	// [RULE_06]
	// Level held until software clears it, keeping the FIFO empty meanwhile
	assign O_FIFO_PTR_RESET = atten_ctrl_r[PTR_RESET_BIT];	// [RULE_07]
	assign O_IRQ_ENABLE     = global_irq_enable_r;

	// Pending summary, gated by the global enable
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			global_irq_pending_r <= 1'b0;	// [RULE_09]
		end else begin
			global_irq_pending_r <= I_IRQ_SOURCE & global_irq_enable_r;	// [RULE_09]
		end
	end
	assign O_IRQ_PENDING = global_irq_pending_r;

	err_counter #(
		.WIDTH      (ERR_COUNT_W)
	) u_err_counter (
		.i_clk      (I_SYS_CLK),
		.i_arst_n   (I_ARST_N),
		.i_count_en (pattern_test_enable),	// [RULE_03]
		.i_err      (I_BIT_ERROR),
		.i_clear    (rd_high | rd_low),	// [RULE_04]
		.o_count    (err_count)
	);

	// Holding register captures the byte not returned by the first read
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			error_count_holding_r <= REG_RESET_VAL;
		end else if (rd_high) begin
			error_count_holding_r <= err_count[7:0];	// [RULE_04]
		end else if (rd_low) begin
			error_count_holding_r <= err_count[15:8];	// [RULE_04]
		end
	end

	// Read mux; anything not decoded returns zero
	always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rdata_r  <= ZERO_BYTE;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= I_REG_RD;
			if (I_REG_RD) begin
				case (I_REG_ADDR)
					LINE_CTRL_ADDR:  rdata_r <= line_ctrl_r;
					ATTEN_CTRL_ADDR: rdata_r <= atten_ctrl_r;
					IRQ_EN_ADDR:     rdata_r <= {7'h00, global_irq_enable_r};
					IRQ_ST_ADDR:     rdata_r <= {7'h00, global_irq_pending_r};	// [RULE_09]
					ERR_HIGH_ADDR:   rdata_r <= err_count[15:8];	// [RULE_10]
					ERR_LOW_ADDR:    rdata_r <= err_count[7:0];	// [RULE_11]
					ERR_HOLD_ADDR:   rdata_r <= error_count_holding_r;
					DEV_ID_ADDR:     rdata_r <= DEVICE_ID;	// [RULE_12]
					SI_REV_ADDR:     rdata_r <= SILICON_REV;	// [RULE_13]
					default:         rdata_r <= ZERO_BYTE;	// [RULE_14]
				endcase
			end
		end
	end
	assign O_REG_RDATA  = rdata_r;
	assign O_REG_RVALID = rvalid_r;

	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_ARST_N);

	property p_loop;
		O_LOOP_MODE == (far_loop_select ? (near_loop_select ? LOOP_DIGITAL : LOOP_REMOTE)
			: (near_loop_select ? LOOP_ANALOG_LOCAL : LOOP_NORMAL));
	endproperty
	a_loop: assert property (p_loop) else $error("Loop mode mismatch");	// [RULE_01]

	property p_pattern;
		I_REG_WR && hit(I_REG_ADDR, LINE_CTRL_ADDR) |=>
			O_PATTERN_DET_EN == $past(I_REG_WDATA[PATTERN_EN_BIT]) && (O_PATTERN_LONG == (O_PATTERN_TX_EN && I_E3_RATE));
	endproperty
	a_pattern: assert property (p_pattern) else $error("Pattern enable mismatch");	// [RULE_02]

	property p_count;
		pattern_test_enable && I_BIT_ERROR && !rd_high && !rd_low && !(&err_count) |=>
			err_count == $past(err_count) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("Error count did not step");	// [RULE_03]

	property p_no_count;
		!pattern_test_enable && !rd_high && !rd_low |=> err_count == $past(err_count);
	endproperty
	a_no_count: assert property (p_no_count) else $error("Count moved while disabled");	// [RULE_03]

	property p_rd_high;
		rd_high |=> O_REG_RVALID && O_REG_RDATA == $past(err_count[15:8])
			&& error_count_holding_r == $past(err_count[7:0]) && err_count <= 16'h0001;
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("High byte read wrong");	// [RULE_10]

	property p_rd_low;
		rd_low |=> O_REG_RDATA == $past(err_count[7:0])
			&& error_count_holding_r == $past(err_count[15:8]) && err_count <= 16'h0001;
	endproperty
	a_rd_low: assert property (p_rd_low) else $error("Low byte read wrong");	// [RULE_11]

	property p_atten;
		O_ATTEN_EN == !atten_mode_bit_a && O_ATTEN_DEPTH_32 == (!atten_mode_bit_a && atten_mode_bit_b)
			&& O_ATTEN_IN_TX == atten_ctrl_r[ATTEN_PATH_BIT];
	endproperty
	a_atten: assert property (p_atten) else $error("Attenuator mode wrong");	// [RULE_05]

	property p_ptr;
		I_REG_WR && hit(I_REG_ADDR, ATTEN_CTRL_ADDR) |=> O_FIFO_PTR_RESET == $past(I_REG_WDATA[PTR_RESET_BIT]);
	endproperty
	a_ptr: assert property (p_ptr) else $error("Pointer reset wrong");	// [RULE_07]

	property p_irq;
		I_IRQ_SOURCE && O_IRQ_ENABLE |=> O_IRQ_PENDING;
	endproperty
	a_irq: assert property (p_irq) else $error("Pending not raised");	// [RULE_09]

	property p_irq_off;
		!O_IRQ_ENABLE |=> !O_IRQ_PENDING;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("Pending while disabled");	// [RULE_08]

	property p_ident;
		I_REG_RD && I_REG_ADDR == DEV_ID_ADDR |=> O_REG_RDATA == DEVICE_ID;
	endproperty
	a_ident: assert property (p_ident) else $error("Identification read wrong");	// [RULE_12]

	property p_rev;
		I_REG_RD && I_REG_ADDR == SI_REV_ADDR |=> O_REG_RDATA == SILICON_REV;
	endproperty
	a_rev: assert property (p_rev) else $error("Revision read wrong");	// [RULE_13]

	property p_reserved;
		I_REG_RD && (I_REG_ADDR == 6'h08 || (I_REG_ADDR >= 6'h22 && I_REG_ADDR <= 6'h2F)
			|| (I_REG_ADDR >= 6'h32 && I_REG_ADDR <= 6'h37) || (I_REG_ADDR >= 6'h39 && I_REG_ADDR <= 6'h3D))
			|=> O_REG_RDATA == ZERO_BYTE;
	endproperty
	a_reserved: assert property (p_reserved) else $error("Reserved read not zero");	// [RULE_14]

	c_rd_high: cover property (rd_high && err_count > 16'h0100);
	c_digital: cover property (O_LOOP_MODE == LOOP_DIGITAL && O_PATTERN_TX_EN);
	c_pending: cover property (O_IRQ_PENDING);
	c_depth32: cover property (O_ATTEN_DEPTH_32 && O_ATTEN_IN_TX);
endmodule // liu_diag_control_registers

/* File: testbench/tb_liu_diag_control_registers.sv */
// Purpose: Self-checking bench for the diagnostic register bank
// Assumes: One-cycle read and write strobes, read data one cycle after the read edge
// Notes:   Inputs change 2 ns after the rising edge to stay clear of sampling
module tb_liu_diag_control_registers;
	timeunit 1ns;
	timeprecision 1ps;
	import liu_diag_pkg::*;

	localparam logic [7:0] ID_VAL  = 8'hC3;	// Arbitrary value
	localparam logic [7:0] REV_VAL = 8'h4B;	// Arbitrary value
	localparam int         LIMIT   = 5000;	// Run needs about 700 cycles

	logic       sys_clk;
	logic       arst_n;
	logic [5:0] addr;
	logic       wr;
	logic [7:0] wdata;
	logic       rd;
	logic [7:0] rdata;
	logic       rvalid;
	logic       e3_rate;
	logic       bit_err;
	logic       irq_src;
	loop_mode_t loop_mode;
	logic       pat_tx, pat_long, pat_det, att_en, att_d32, att_tx, ptr_rst, irq_en, irq_pend;
	int         n_fail;
	int         comparisons;
	int         cycles = 0;
	logic [5:0] rsvd [7] = '{6'h08, 6'h22, 6'h2F, 6'h32, 6'h37, 6'h39, 6'h3D};

	liu_diag_control_registers #(.DEVICE_ID(ID_VAL), .SILICON_REV(REV_VAL)) dut (
		.I_SYS_CLK(sys_clk), .I_ARST_N(arst_n), .I_REG_ADDR(addr), .I_REG_WR(wr),
		.I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
		.I_E3_RATE(e3_rate), .I_BIT_ERROR(bit_err), .I_IRQ_SOURCE(irq_src),
		.O_LOOP_MODE(loop_mode), .O_PATTERN_TX_EN(pat_tx), .O_PATTERN_LONG(pat_long),
		.O_PATTERN_DET_EN(pat_det), .O_ATTEN_EN(att_en), .O_ATTEN_DEPTH_32(att_d32),
		.O_ATTEN_IN_TX(att_tx), .O_FIFO_PTR_RESET(ptr_rst), .O_IRQ_ENABLE(irq_en),
		.O_IRQ_PENDING(irq_pend)
	);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic give_verdict();
		if (n_fail == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic step();
		@(posedge sys_clk);
		#2;
	endtask

	task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		step();
		wr = 1'b0;
		// Idle edge so back-to-back calls never retoggle the strobe in one step
		step();
	endtask

	// Read data is checked in the cycle that the valid pulse stands
	task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		step();
		rd = 1'b0;
		chk({15'h0, rvalid}, 16'h0001);
		chk({8'h0, rdata}, {8'h0, exp});
		step();
	endtask

	// Gaps between pulses keep each error a single-cycle event
	task automatic errs(input int n);
		repeat (n) begin
			bit_err = 1'b1;
			step();
			bit_err = 1'b0;
			step();
		end
	endtask

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		{addr, wr, wdata, rd, e3_rate, bit_err, irq_src} = '0;
		arst_n = 1'b0;
		n_fail = 0;
		comparisons = 0;
		repeat (12) @(posedge sys_clk);
		#2;
		arst_n = 1'b1;
		reg_rd(IRQ_EN_ADDR, 8'h00);
		reg_rd(IRQ_ST_ADDR, 8'h00);
		for (int i = 0; i < 4; i++) begin
			reg_wr(LINE_CTRL_ADDR, {3'h0, i[1:0], 3'h0});
			chk({14'h0, loop_mode}, i[15:0]);
		end
		reg_wr(LINE_CTRL_ADDR, 8'h38);
		for (int i = 0; i < 2; i++) begin
			e3_rate = i[0];
			step();
			chk({13'h0, pat_tx, pat_det, pat_long}, {13'h0, 2'h3, i[0]});
			chk({14'h0, loop_mode}, {14'h0, LOOP_DIGITAL});
		end
		reg_wr(LINE_CTRL_ADDR, 8'h00);
		chk({13'h0, pat_tx, pat_det, pat_long}, 16'h0000);
		for (int i = 0; i < 16; i++) begin
			reg_wr(ATTEN_CTRL_ADDR, i[7:0]);
			chk({12'h0, att_en, att_d32, att_tx, ptr_rst}, {12'h0, ~i[0], ~i[0] & i[2], i[1], i[3]});
			reg_rd(ATTEN_CTRL_ADDR, i[7:0]);
		end
		// Summary stays low until the global enable is set
		irq_src = 1'b1;
		step();
		step();
		reg_rd(IRQ_ST_ADDR, 8'h00);
		reg_wr(IRQ_EN_ADDR, 8'h01);
		chk({15'h0, irq_en}, 16'h0001);
		step();
		reg_rd(IRQ_ST_ADDR, 8'h01);
		chk({15'h0, irq_pend}, 16'h0001);
		reg_rd(IRQ_EN_ADDR, 8'h01);
		irq_src = 1'b0;
		step();
		step();
		reg_rd(IRQ_ST_ADDR, 8'h00);
		// Errors before pattern enable must not count
		errs(3);
		reg_wr(LINE_CTRL_ADDR, 8'h20);
		errs(259);
		reg_rd(ERR_HIGH_ADDR, 8'h01);
		reg_rd(ERR_HOLD_ADDR, 8'h03);
		reg_rd(ERR_LOW_ADDR, 8'h00);
		reg_rd(ERR_HIGH_ADDR, 8'h00);
		errs(5);
		reg_rd(ERR_LOW_ADDR, 8'h05);
		reg_rd(ERR_HOLD_ADDR, 8'h00);
		reg_wr(DEV_ID_ADDR, 8'hFF);
		reg_rd(DEV_ID_ADDR, ID_VAL);
		reg_wr(SI_REV_ADDR, 8'hFF);
		reg_rd(SI_REV_ADDR, REV_VAL);
		foreach (rsvd[k]) begin
			reg_wr(rsvd[k], 8'hFF);
			reg_rd(rsvd[k], 8'h00);
		end
		give_verdict();
	end
endmodule // tb_liu_diag_control_registers
